// File: shared/xoac_pkg.sv
// constants and types shared by the crystal autostart oscillator control
package xoac_pkg;
   // energy modes reported by the energy-mode controller
   typedef enum logic [2:0] {
      EM_ACTIVE, EM_SLEEP, EM_DEEP_SLEEP, EM_STOP, EM_HIBERNATE, EM_SHUTOFF
   } xoac_em_type;
   // high-frequency source clock choices
   typedef enum logic [1:0] {
      SRC_HF_RC, SRC_FAST_XO, SRC_SLOW_XO, SRC_SLOW_RC
   } xoac_src_type;
   // fast crystal sequencer phases
   typedef enum logic [1:0] {
      XO_OFF, XO_STARTUP, XO_STEADY, XO_READY
   } xoac_xo_type;
   // timeout counter width
   localparam int TMO_W = 16;
   // interrupt flag bit positions
   localparam int FLAG_W = 4;
   localparam int FLAG_DIS_ERR = 0;
   localparam int FLAG_AUTO_SW = 1;
   localparam int FLAG_RC_DIS = 2;
   localparam int FLAG_UNIT_ERR = 3;
   // slow crystal control word: mode [1:0], timeout [5:2], gain [7:6]
   localparam int LF_W = 8;
   localparam int LF_MODE_LSB = 0;
   localparam int LF_TMO_LSB = 2;
   localparam int LF_GAIN_LSB = 6;
   localparam logic [1:0] LF_MODE_XTAL = 2'h0;
   localparam logic [1:0] LF_MODE_SINE = 2'h1; // ext_sine_bypass
   localparam logic [1:0] LF_MODE_SQUARE = 2'h2; // ext_square_bypass
   localparam logic [LF_W-1:0] LF_CTRL_RESET = 8'hFC; // max timeout, max gain
   // rc oscillator fields
   localparam int BAND_W = 3;
   localparam int COARSE_W = 7;
   localparam int FINE_W = 6;
   localparam int DIV_W = 2;
   localparam logic [BAND_W-1:0] BAND_1MHZ = 3'h0;
   localparam logic [BAND_W-1:0] BAND_19MHZ = 3'h4;
   localparam logic [BAND_W-1:0] BAND_48MHZ = 3'h7;
   localparam logic [DIV_W-1:0] DIV_BY1 = 2'h0;
   localparam logic [DIV_W-1:0] DIV_BY2 = 2'h1;
   localparam logic [DIV_W-1:0] DIV_BY4 = 2'h2;
endpackage : xoac_pkg

// File: hw/xoac_rc_trim.sv
// tuning, band and output prescaler of one internal hf rc oscillator
`timescale 1ns/1ps
module xoac_rc_trim
   import xoac_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic [COARSE_W-1:0] cal_coarse, // calibrated coarse for 19 MHz band
   input wire logic [FINE_W-1:0] cal_fine, // calibrated fine for 19 MHz band
   input wire logic wr, // control write strobe
   input wire logic [BAND_W-1:0] wr_band, // band_select_field
   input wire logic [COARSE_W-1:0] wr_coarse, // coarse tuning
   input wire logic [FINE_W-1:0] wr_fine, // fine_trim_field
   input wire logic wr_fine_en, // fine_trim_enable
   input wire logic [DIV_W-1:0] wr_div, // output_divide_field
   input wire logic run, // oscillator enabled
   output logic [BAND_W-1:0] band, // applied band
   output logic [COARSE_W-1:0] coarse, // applied coarse trim
   output logic [FINE_W-1:0] fine_eff, // fine trim seen by the core
   output logic fine_en, // fine trim enabled
   output logic [DIV_W-1:0] div, // applied prescaler setting
   output logic div_tick // one pulse per divided output period
);
   import xoac_pkg::*;

   typedef struct packed {
      logic [BAND_W-1:0] band;
      logic [COARSE_W-1:0] coarse;
      logic [FINE_W-1:0] fine;
      logic fine_en;
      logic [DIV_W-1:0] div;
      logic [1:0] cnt;
      logic tick;
   } xoac_rc_type;

   xoac_rc_type s_reg; // current state
   xoac_rc_type s_next; // next state

   // next state: field writes and prescaler counter
   always_comb
   begin
      s_next = s_reg;
      if (wr)
      begin
         s_next.band = wr_band;
         s_next.coarse = wr_coarse;
         s_next.fine = wr_fine;
         s_next.fine_en = wr_fine_en;
         s_next.div = wr_div;
      end
      // divide by 1, 2 or 4; unknown codes act as 1 so the clock never stops
      s_next.tick = 1'b0;
      if (!run)
         s_next.cnt = 2'h0;
      else
      begin
         s_next.cnt = s_reg.cnt + 2'h1;
         case (s_reg.div)
            DIV_BY2: s_next.tick = s_reg.cnt[0];
            DIV_BY4: s_next.tick = (s_reg.cnt == 2'h3);
            default: s_next.tick = 1'b1;
         endcase
      end
   end

   // register; reset loads the 19 MHz calibration
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.band <= BAND_19MHZ;
         s_reg.coarse <= cal_coarse;
         s_reg.fine <= cal_fine;
      end
      else
         s_reg <= s_next;
   end

   assign band = s_reg.band;
   // larger code means a slower oscillator, the analog core sees it as is
   assign coarse = s_reg.coarse;
   // fine trim only steers the core while enabled
   assign fine_eff = s_reg.fine_en ? s_reg.fine : '0;
   assign fine_en = s_reg.fine_en;
   assign div = s_reg.div;
   assign div_tick = s_reg.tick;
endmodule : xoac_rc_trim

// File: hw/xoac_top.sv
// fast crystal autostart, source selection and oscillator control fields
//
// Function
// - auto enable fast crystal in active/sleep
// - auto select fast crystal when select bit set
// - refuse disable under auto enable, flag error
// - refuse deselect under auto select, flag error
// - refusals never set general unit error
// - hardware stops crystal only in low modes
// - auto select switches at once, unready
// - auto switch sets auto switch flag
// - then stop running hf rc, flag it
// - slow crystal left running by switch
// - slow crystal sine and square bypass modes
// - slow crystal config latched through hibernate
// - larger tuning value gives lower frequency
// - band select spans 1 to 48 MHz
// - reset loads 19 MHz calibrated tuning
// - fine trim acts only while enabled
// - rc prescaler divides by 1, 2, 4
// - reset, and wake without auto select, pick hf rc source
// - ready after startup plus steady timeout
`timescale 1ns/1ps
module xoac_top
   import xoac_pkg::*;
(
   input wire logic clock, // 50 MHz system clock
   input wire logic rst, // sync reset, active high
   input wire xoac_em_type energy_mode, // current energy mode
   input wire logic autostart_enable_bit, // auto enable in active/sleep
   input wire logic autostart_select_bit, // auto enable and select
   input wire logic fast_crystal_enable_cmd, // pulse: software enable
   input wire logic fast_crystal_disable_cmd, // pulse: software disable
   input wire logic rc_enable_cmd, // pulse: enable hf rc
   input wire logic rc_disable_cmd, // pulse: disable hf rc
   input wire logic src_select_cmd, // pulse: choose hf source
   input wire xoac_src_type src_select_val, // source to choose
   input wire logic [TMO_W-1:0] startup_timeout, // startup phase cycles
   input wire logic [TMO_W-1:0] steady_timeout, // steady phase cycles
   input wire logic [FLAG_W-1:0] flag_clear, // pulses: clear flags
   input wire logic slow_enable_cmd, // pulse: enable slow crystal
   input wire logic slow_disable_cmd, // pulse: disable slow crystal
   input wire logic slow_ctrl_wr, // slow crystal control write
   input wire logic [LF_W-1:0] slow_ctrl_wdata, // mode, timeout, gain
   input wire logic slow_retain, // keep slow crystal through hibernate
   input wire logic retention_unlatch_cmd, // pulse: release latched config
   input wire logic [COARSE_W-1:0] cal_coarse, // 19 MHz calibrated coarse
   input wire logic [FINE_W-1:0] cal_fine, // 19 MHz calibrated fine
   input wire logic rc_ctrl_wr, // hf rc control write
   input wire logic aux_ctrl_wr, // auxiliary rc control write
   input wire logic [BAND_W-1:0] rc_wr_band, // band_select_field
   input wire logic [COARSE_W-1:0] rc_wr_coarse, // coarse tuning
   input wire logic [FINE_W-1:0] rc_wr_fine, // fine_trim_field
   input wire logic rc_wr_fine_en, // fine_trim_enable
   input wire logic [DIV_W-1:0] rc_wr_div, // output_divide_field
   input wire logic aux_run, // auxiliary rc enabled
   output xoac_src_type hf_source_clock, // selected hf source
   output logic fast_crystal_on, // crystal enabled status
   output logic fast_crystal_ready, // crystal ready status
   output logic rc_on, // hf rc enabled status
   output logic slow_crystal_on, // slow crystal running
   output logic [FLAG_W-1:0] flags, // sticky interrupt flags
   output logic [LF_W-1:0] slow_ctrl, // control register view
   output logic [LF_W-1:0] slow_cfg_applied, // config driving the crystal
   output logic slow_latched, // retained config active
   output logic [BAND_W-1:0] rc_band, // hf rc band
   output logic [COARSE_W-1:0] rc_coarse, // hf rc coarse trim
   output logic [FINE_W-1:0] rc_fine, // hf rc effective fine trim
   output logic rc_fine_en, // hf rc fine trim enable
   output logic [DIV_W-1:0] rc_div, // hf rc prescaler
   output logic rc_tick, // hf rc divided clock tick
   output logic [BAND_W-1:0] aux_band, // aux rc band
   output logic [COARSE_W-1:0] aux_coarse, // aux rc coarse trim
   output logic [FINE_W-1:0] aux_fine, // aux rc effective fine trim
   output logic aux_fine_en, // aux rc fine trim enable
   output logic [DIV_W-1:0] aux_div, // aux rc prescaler
   output logic aux_tick // aux rc divided clock tick
);
   import xoac_pkg::*;

   // true in the two modes where the hf oscillators may run
   function automatic logic is_awake(input xoac_em_type m);
      is_awake = (m == EM_ACTIVE) || (m == EM_SLEEP);
   endfunction : is_awake

   typedef struct packed {
      logic xo_en; // crystal enable
      xoac_xo_type phase; // startup sequencer phase
      logic [TMO_W-1:0] cnt; // phase counter
      xoac_src_type src; // hf source
      logic rc_en; // hf rc enable
      logic [FLAG_W-1:0] flags; // sticky flags
      logic awake; // previous cycle was awake
      logic lf_en; // slow crystal enable
      logic [LF_W-1:0] lf_ctrl; // slow crystal control register
      logic [LF_W-1:0] lf_held; // retained config
      logic lf_latched; // retained config in use
   } xoac_state_type;

   xoac_state_type s_reg; // current state
   xoac_state_type s_next; // next state

   logic awake; // active or sleep now
   logic auto_en; // automatic enable condition
   logic auto_sel; // automatic select condition
   logic [FLAG_W-1:0] set_f; // flag set events this cycle

   // automatic conditions, decoded straight from mode and bits
   always_comb
   begin
      awake = is_awake(energy_mode);
      auto_en = awake && (autostart_enable_bit || autostart_select_bit);
      auto_sel = awake && autostart_select_bit;
   end

   // next state of the whole controller
   always_comb
   begin
      s_next = s_reg;
      set_f = '0;
      s_next.awake = awake;

      // software crystal commands
      if (fast_crystal_enable_cmd)
         s_next.xo_en = 1'b1;
      if (fast_crystal_disable_cmd)
      begin
         if (auto_en)
            set_f[FLAG_DIS_ERR] = 1'b1;
         else
            s_next.xo_en = 1'b0;
      end

      // software rc commands
      if (rc_enable_cmd)
         s_next.rc_en = 1'b1;
      if (rc_disable_cmd)
         s_next.rc_en = 1'b0;

      // software source selection
      if (src_select_cmd)
      begin
         if (auto_sel && (src_select_val != SRC_FAST_XO))
            set_f[FLAG_DIS_ERR] = 1'b1;
         else
         begin
            s_next.src = src_select_val;
            // choosing a stopped oscillator stalls the clock tree
            case (src_select_val)
               SRC_FAST_XO: set_f[FLAG_UNIT_ERR] = !s_next.xo_en;
               SRC_HF_RC: set_f[FLAG_UNIT_ERR] = !s_next.rc_en;
               SRC_SLOW_XO: set_f[FLAG_UNIT_ERR] = !s_reg.lf_en;
               default: set_f[FLAG_UNIT_ERR] = 1'b0;
            endcase
         end
      end

      // automatic enable starts the normal sequence below
      if (auto_en)
         s_next.xo_en = 1'b1;

      // wake into active/sleep restarts on the hf rc unless auto select switches it below
      if (awake && !s_reg.awake)
      begin
         s_next.rc_en = 1'b1;
         s_next.src = SRC_HF_RC;
      end

      // automatic select switches immediately, ready or not
      if (auto_sel)
      begin
         if (s_next.src != SRC_FAST_XO)
            set_f[FLAG_AUTO_SW] = 1'b1;
         s_next.src = SRC_FAST_XO;
         // the slow crystal enable is not touched here
         if (s_reg.rc_en && (s_reg.src == SRC_FAST_XO) && s_reg.xo_en)
         begin
            s_next.rc_en = 1'b0;
            set_f[FLAG_RC_DIS] = 1'b1;
         end
      end

      // low modes: the hardware stops both hf oscillators here, the crystal only here
      if (!awake)
      begin
         s_next.xo_en = 1'b0;
         s_next.rc_en = 1'b0;
      end

      // crystal startup then steady timeout before ready
      if (!s_next.xo_en)
      begin
         s_next.phase = XO_OFF;
         s_next.cnt = '0;
      end
      else
      begin
         case (s_reg.phase)
            XO_OFF:
            begin
               s_next.phase = XO_STARTUP;
               s_next.cnt = '0;
            end
            XO_STARTUP:
               if (s_reg.cnt >= startup_timeout)
               begin
                  s_next.phase = XO_STEADY;
                  s_next.cnt = '0;
               end
               else
                  s_next.cnt = s_reg.cnt + 1'b1;
            XO_STEADY:
               if (s_reg.cnt >= steady_timeout)
                  s_next.phase = XO_READY;
               else
                  s_next.cnt = s_reg.cnt + 1'b1;
            default:
               s_next.phase = XO_READY;
         endcase
      end

      // sticky flags: a set in the clearing cycle wins
      s_next.flags = (s_reg.flags & ~flag_clear) | set_f;

      // slow crystal commands and control register
      if (slow_enable_cmd)
         s_next.lf_en = 1'b1;
      if (slow_disable_cmd)
         s_next.lf_en = 1'b0;
      if (slow_ctrl_wr)
         s_next.lf_ctrl = slow_ctrl_wdata;
      if (retention_unlatch_cmd)
         s_next.lf_latched = 1'b0;

      // hibernate/shutoff: register resets, retained config is held
      if ((energy_mode == EM_HIBERNATE) || (energy_mode == EM_SHUTOFF))
      begin
         if (!s_reg.lf_latched)
            s_next.lf_held = s_reg.lf_ctrl;
         s_next.lf_latched = slow_retain && s_reg.lf_en;
         s_next.lf_en = slow_retain && s_reg.lf_en;
         s_next.lf_ctrl = LF_CTRL_RESET;
      end
      else if (energy_mode == EM_STOP)
         s_next.lf_en = 1'b0; // slow oscillators off in stop by definition
   end

   // one register for all controller state
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.src <= SRC_HF_RC;
         s_reg.rc_en <= 1'b1;
         s_reg.phase <= XO_OFF;
         s_reg.awake <= 1'b1;
         s_reg.lf_ctrl <= LF_CTRL_RESET;
      end
      else
         s_reg <= s_next;
   end

   // status outputs, all straight from the register
   assign hf_source_clock = s_reg.src;
   assign fast_crystal_on = s_reg.xo_en;
   assign fast_crystal_ready = (s_reg.phase == XO_READY);
   assign rc_on = s_reg.rc_en;
   assign slow_crystal_on = s_reg.lf_en;
   assign flags = s_reg.flags;
   assign slow_ctrl = s_reg.lf_ctrl;
   // software may rewrite a short timeout before unlatching
   assign slow_cfg_applied = s_reg.lf_latched ? s_reg.lf_held : s_reg.lf_ctrl;
   assign slow_latched = s_reg.lf_latched;

   // hf rc trim, runs while enabled
   xoac_rc_trim u_rc (
      .clock(clock),
      .rst(rst),
      .cal_coarse(cal_coarse),
      .cal_fine(cal_fine),
      .wr(rc_ctrl_wr),
      .wr_band(rc_wr_band),
      .wr_coarse(rc_wr_coarse),
      .wr_fine(rc_wr_fine),
      .wr_fine_en(rc_wr_fine_en),
      .wr_div(rc_wr_div),
      .run(s_reg.rc_en),
      .band(rc_band),
      .coarse(rc_coarse),
      .fine_eff(rc_fine),
      .fine_en(rc_fine_en),
      .div(rc_div),
      .div_tick(rc_tick)
   );

   // auxiliary rc trim, shares the calibration and write data
   xoac_rc_trim u_aux (
      .clock(clock),
      .rst(rst),
      .cal_coarse(cal_coarse),
      .cal_fine(cal_fine),
      .wr(aux_ctrl_wr),
      .wr_band(rc_wr_band),
      .wr_coarse(rc_wr_coarse),
      .wr_fine(rc_wr_fine),
      .wr_fine_en(rc_wr_fine_en),
      .wr_div(rc_wr_div),
      .run(aux_run),
      .band(aux_band),
      .coarse(aux_coarse),
      .fine_eff(aux_fine),
      .fine_en(aux_fine_en),
      .div(aux_div),
      .div_tick(aux_tick)
   );
endmodule : xoac_top

// File: verification/xoac_properties.sv
// assertions on the ports of the crystal autostart control
`timescale 1ns/1ps
module xoac_properties
   import xoac_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // sync reset
   input wire xoac_em_type energy_mode, // energy mode
   input wire logic autostart_enable_bit, // auto enable
   input wire logic autostart_select_bit, // auto select
   input wire logic fast_crystal_disable_cmd, // sw disable
   input wire logic rc_enable_cmd, // rc enable
   input wire logic src_select_cmd, // sw select
   input wire xoac_src_type src_select_val, // select value
   input wire logic [TMO_W-1:0] startup_timeout, // startup cycles
   input wire logic [TMO_W-1:0] steady_timeout, // steady cycles
   input wire logic [FLAG_W-1:0] flag_clear, // flag clears
   input wire xoac_src_type hf_source_clock, // source
   input wire logic fast_crystal_on, // crystal on
   input wire logic fast_crystal_ready, // crystal ready
   input wire logic rc_on, // rc on
   input wire logic [FLAG_W-1:0] flags // sticky flags
);
   logic awake; // active or sleep
   logic [TMO_W+1:0] on_cnt_reg; // cycles crystal stood on
   assign awake = (energy_mode == EM_ACTIVE) || (energy_mode == EM_SLEEP);
   // wide enough that the two timeouts never overflow it
   always_ff @(posedge clock)
   begin
      if (rst || !fast_crystal_on)
         on_cnt_reg <= '0;
      else
         on_cnt_reg <= on_cnt_reg + 1'b1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_auto_enable: assert property (
      awake && (autostart_enable_bit || autostart_select_bit) |=> fast_crystal_on)
      else $error("crystal not auto enabled");
   a_auto_select: assert property (
      awake && autostart_select_bit |=> hf_source_clock == SRC_FAST_XO)
      else $error("crystal not auto selected");
   a_low_off: assert property (
      !awake |=> !fast_crystal_on && !rc_on)
      else $error("oscillator left on in low mode");
   a_only_stop: assert property (
      $fell(fast_crystal_on) |-> $past(fast_crystal_disable_cmd) || !$past(awake))
      else $error("crystal stopped without cause");
   a_dis_refused: assert property (
      fast_crystal_disable_cmd && awake && (autostart_enable_bit || autostart_select_bit)
      |=> fast_crystal_on && flags[FLAG_DIS_ERR])
      else $error("disable not refused");
   a_desel_refused: assert property (
      src_select_cmd && src_select_val != SRC_FAST_XO && awake && autostart_select_bit
      && !flag_clear[FLAG_UNIT_ERR] |=> hf_source_clock == SRC_FAST_XO
      && flags[FLAG_DIS_ERR] && flags[FLAG_UNIT_ERR] == $past(flags[FLAG_UNIT_ERR]))
      else $error("deselect not refused");
   a_switch_flag: assert property (
      awake && autostart_select_bit && hf_source_clock != SRC_FAST_XO
      |=> flags[FLAG_AUTO_SW])
      else $error("auto switch flag missing");
   a_rc_stopped: assert property (
      awake && autostart_select_bit && hf_source_clock == SRC_FAST_XO && fast_crystal_on
      && rc_on && !rc_enable_cmd |=> !rc_on && flags[FLAG_RC_DIS])
      else $error("rc not stopped after switch");
   a_wake_rc: assert property (
      !$past(awake) && !$past(rst) && awake && !autostart_select_bit && !src_select_cmd
      |=> hf_source_clock == SRC_HF_RC && rc_on)
      else $error("wake did not pick rc");
   a_ready_late: assert property (
      $rose(fast_crystal_ready) |-> on_cnt_reg >= startup_timeout + steady_timeout)
      else $error("ready too early");
endmodule : xoac_properties

bind xoac_top xoac_properties xoac_properties_i (
   .clock(clock), .rst(rst), .energy_mode(energy_mode),
   .autostart_enable_bit(autostart_enable_bit), .autostart_select_bit(autostart_select_bit),
   .fast_crystal_disable_cmd(fast_crystal_disable_cmd), .rc_enable_cmd(rc_enable_cmd),
   .src_select_cmd(src_select_cmd), .src_select_val(src_select_val),
   .startup_timeout(startup_timeout), .steady_timeout(steady_timeout),
   .flag_clear(flag_clear), .hf_source_clock(hf_source_clock),
   .fast_crystal_on(fast_crystal_on), .fast_crystal_ready(fast_crystal_ready),
   .rc_on(rc_on), .flags(flags)
);

// File: verification/xoac_top_tb.sv
// self-checking bench for the crystal autostart control
`timescale 1ns/1ps
module xoac_top_tb;
   import xoac_pkg::*;
   logic clock, rst = 1, autostart_enable_bit = 0, autostart_select_bit = 0;
   xoac_em_type energy_mode = EM_ACTIVE; // awake during reset
   xoac_src_type src_select_val = SRC_HF_RC, hf_source_clock;
   logic fast_crystal_enable_cmd = 0, fast_crystal_disable_cmd = 0, rc_enable_cmd = 0;
   logic rc_disable_cmd = 0, src_select_cmd = 0, slow_enable_cmd = 0, slow_disable_cmd = 0;
   logic slow_ctrl_wr = 0, slow_retain = 0, retention_unlatch_cmd = 0, rc_ctrl_wr = 0;
   logic aux_ctrl_wr = 0, rc_wr_fine_en = 0, aux_run = 1;
   logic [TMO_W-1:0] startup_timeout = 16'h0003, steady_timeout = 16'h0002; // short counts
   logic [FLAG_W-1:0] flag_clear = 4'h0, flags;
   logic [LF_W-1:0] slow_ctrl_wdata = 8'h00, slow_ctrl, slow_cfg_applied;
   logic [COARSE_W-1:0] cal_coarse = 7'h2A, rc_wr_coarse = 7'h7F, rc_coarse, aux_coarse;
   logic [FINE_W-1:0] cal_fine = 6'h15, rc_wr_fine = 6'h3F, rc_fine, aux_fine;
   logic [BAND_W-1:0] rc_wr_band = BAND_19MHZ, rc_band, aux_band;
   logic [DIV_W-1:0] rc_wr_div = DIV_BY1, rc_div, aux_div;
   logic fast_crystal_on, fast_crystal_ready, rc_on, slow_crystal_on, slow_latched;
   logic rc_fine_en, rc_tick, aux_fine_en, aux_tick;
   int error_cnt = 0, checks_done = 0, n;
   xoac_top xoac_top_i (.clock, .rst, .energy_mode, .autostart_enable_bit,
      .autostart_select_bit, .fast_crystal_enable_cmd, .fast_crystal_disable_cmd,
      .rc_enable_cmd, .rc_disable_cmd, .src_select_cmd, .src_select_val, .startup_timeout,
      .steady_timeout, .flag_clear, .slow_enable_cmd, .slow_disable_cmd, .slow_ctrl_wr,
      .slow_ctrl_wdata, .slow_retain, .retention_unlatch_cmd, .cal_coarse, .cal_fine,
      .rc_ctrl_wr, .aux_ctrl_wr, .rc_wr_band, .rc_wr_coarse, .rc_wr_fine, .rc_wr_fine_en,
      .rc_wr_div, .aux_run, .hf_source_clock, .fast_crystal_on, .fast_crystal_ready, .rc_on,
      .slow_crystal_on, .flags, .slow_ctrl, .slow_cfg_applied, .slow_latched, .rc_band,
      .rc_coarse, .rc_fine, .rc_fine_en, .rc_div, .rc_tick, .aux_band, .aux_coarse, .aux_fine,
      .aux_fine_en, .aux_div, .aux_tick);
   // free running 50 MHz clock
   initial
   begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   // step k edges, land just after the last one
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : cyc
   // one-cycle command; the idle cycle after keeps re-pulses apart
   task automatic pulse(ref logic s);
      s = 1;
      cyc(1);
      s = 0;
      cyc(1);
   endtask : pulse
   // four-state compare of one result
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // run takes about 90 cycles; this allows over thirty times that
   initial
   begin
      #60000;
      error_cnt++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      cyc(6);
      rst = 0;
      chk("src", SRC_HF_RC, hf_source_clock);
      chk("rc_on", 1, rc_on);
      chk("flags", 0, flags);
      chk("slow_ctrl", LF_CTRL_RESET, slow_ctrl);
      chk("band", BAND_19MHZ, rc_band);
      chk("coarse", cal_coarse, rc_coarse);
      chk("aux_coarse", cal_coarse, aux_coarse);
      // slowest tuning first, only then leave the 19 MHz band
      pulse(rc_ctrl_wr);
      rc_wr_band = BAND_48MHZ;
      pulse(rc_ctrl_wr);
      chk("band", BAND_48MHZ, rc_band);
      chk("coarse", 7'h7F, rc_coarse);
      chk("fine_off", 0, rc_fine);
      rc_wr_fine_en = 1;
      pulse(rc_ctrl_wr);
      chk("fine_on", 6'h3F, rc_fine);
      chk("fine_en", 1, rc_fine_en);
      pulse(aux_ctrl_wr);
      chk("aux_fine", 6'h3F, aux_fine);
      chk("aux_fine_en", 1, aux_fine_en);
      chk("aux_band", BAND_48MHZ, aux_band);
      chk("aux_div", DIV_BY1, aux_div);
      chk("aux_tick", 1, aux_tick);
      rc_wr_band = BAND_1MHZ;
      pulse(rc_ctrl_wr);
      chk("band", BAND_1MHZ, rc_band);
      // divide by 1, 2, 4: ticks in eight cycles
      for (int d = 0; d < 3; d++)
      begin
         rc_wr_div = d[DIV_W-1:0];
         pulse(rc_ctrl_wr);
         chk("rc_div", 16'(d), rc_div);
         n = 0;
         repeat (8)
         begin
            cyc(1);
            if (rc_tick === 1'b1)
               n++;
         end
         chk("rc_ticks", 16'(8 >> d), 16'(n));
      end
      // slow crystal drives the source first
      pulse(slow_enable_cmd);
      src_select_val = SRC_SLOW_XO;
      pulse(src_select_cmd);
      autostart_enable_bit = 1;
      cyc(1);
      chk("xo_on", 1, fast_crystal_on);
      chk("src", SRC_SLOW_XO, hf_source_clock);
      n = 1;
      while (fast_crystal_ready !== 1'b1 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk("ready", 1, fast_crystal_ready);
      chk("ready_late", 1, n > startup_timeout + steady_timeout);
      pulse(fast_crystal_disable_cmd);
      chk("xo_on", 1, fast_crystal_on);
      chk("flags", 4'h1, flags);
      flag_clear = 4'hF;
      cyc(1);
      flag_clear = 4'h0;
      autostart_select_bit = 1;
      cyc(1);
      chk("src", SRC_FAST_XO, hf_source_clock);
      cyc(1);
      chk("flags", 4'h6, flags);
      chk("rc_on", 0, rc_on);
      chk("slow_on", 1, slow_crystal_on);
      src_select_val = SRC_HF_RC;
      pulse(src_select_cmd);
      chk("src", SRC_FAST_XO, hf_source_clock);
      chk("flags", 4'h7, flags);
      // low mode stops both, wake goes straight to crystal
      energy_mode = EM_DEEP_SLEEP;
      cyc(2);
      chk("xo_on", 0, fast_crystal_on);
      chk("rc_on", 0, rc_on);
      energy_mode = EM_ACTIVE;
      cyc(1);
      chk("src", SRC_FAST_XO, hf_source_clock);
      autostart_select_bit = 0;
      autostart_enable_bit = 0;
      energy_mode = EM_STOP;
      cyc(2);
      energy_mode = EM_ACTIVE;
      cyc(1);
      chk("src", SRC_HF_RC, hf_source_clock);
      chk("rc_on", 1, rc_on);
      pulse(fast_crystal_enable_cmd);
      pulse(fast_crystal_disable_cmd);
      chk("xo_on", 0, fast_crystal_on);
      // selecting the stopped crystal is a plain unit error
      src_select_val = SRC_FAST_XO;
      pulse(src_select_cmd);
      chk("flags", 4'hF, flags);
      // bypass modes and retention through hibernate
      pulse(slow_enable_cmd);
      slow_ctrl_wdata = {6'h00, LF_MODE_SINE};
      pulse(slow_ctrl_wr);
      chk("slow_ctrl", {8'h00, LF_MODE_SINE}, slow_ctrl);
      slow_ctrl_wdata = {6'h00, LF_MODE_SQUARE};
      pulse(slow_ctrl_wr);
      chk("slow_ctrl", {8'h00, LF_MODE_SQUARE}, slow_ctrl);
      slow_retain = 1;
      energy_mode = EM_HIBERNATE;
      cyc(2);
      chk("slow_ctrl", LF_CTRL_RESET, slow_ctrl);
      chk("slow_cfg", {8'h00, LF_MODE_SQUARE}, slow_cfg_applied);
      chk("latched", 1, slow_latched);
      energy_mode = EM_ACTIVE;
      cyc(1);
      pulse(slow_ctrl_wr);
      pulse(slow_enable_cmd);
      pulse(retention_unlatch_cmd);
      chk("latched", 0, slow_latched);
      chk("slow_on", 1, slow_crystal_on);
      chk("slow_cfg", {8'h00, LF_MODE_SQUARE}, slow_cfg_applied);
      end_of_test();
   end
endmodule : xoac_top_tb
